// File: dcm_clock_dist.sv
/*
 * Clock multiplier and distribution for an interpolating DAC: prescaler, lock
 * detection, 1x/2x/4x rate enables, input latch and zero-stuff multiplexer.
 * Assumes clk stands for the oscillator rate; pins come from another domain.
 */
`timescale 1ns/1ps

module dcm_clock_dist (
	input  wire logic         clk,                    // Oscillator-rate clock
	input  wire logic         rst_n,                  // Asynchronous reset, active low
	input  wire logic         multiplier_enable,      // Loop enabled
	input  wire logic         ref_clk_in,             // Reference clock pin
	input  wire logic         align_reset,            // Divider alignment pin
	input  wire logic         zero_stuff_select,      // Zero-stuffing mode
	input  wire logic         filter_highpass_select, // Filter response select
	input  wire logic         prescale_sel_hi,        // Prescaler code, upper bit
	input  wire logic         prescale_sel_lo,        // Prescaler code, lower bit
	input  wire logic [13:0]  data_in,                // Word from the data source
	input  wire logic [13:0]  interp_data,            // Word from the interpolator
	output logic              lock_or_clk1x_out,      // Lock level or 1x clock
	output logic              locked,                 // Loop lock state
	output logic              en1x,                   // 1x rate pulse
	output logic              en2x,                   // 2x rate pulse
	output logic              en4x,                   // 4x rate pulse
	output logic [13:0]       latched_data,           // Captured input word
	output logic              latch_strobe,           // Capture pulse
	output logic [13:0]       dac_code,               // Converter code
	output logic              dac_update,             // Converter update pulse
	output logic              highpass_out            // Filter response to interpolator
);

	dcm_pkg::dcm_state_t s;         // Registered state
	dcm_pkg::dcm_state_t next_s;    // Next state
	dcm_pkg::dcm_pins_t  pins_raw;  // Pins gathered
	dcm_pkg::dcm_pins_t  agree;     // Stages two and three equal
	logic                ref_rise;  // Reference rising edge
	logic                align_rise;// Align rising edge
	logic                pll_tick;  // Prescaler output pulse
	logic                tick;      // DAC update rate pulse
	logic [3:0]          ratio;     // Divide ratio
	logic [2:0]          div_last;  // Last prescaler count
	logic [1:0]          ph_last;   // Last phase of a data period
	logic [3:0]          expected;  // Ticks expected per reference window
	logic                wrap;      // Data period ends on this tick

	assign pins_raw = '{zero_stuff: zero_stuff_select, highpass: filter_highpass_select,
		prescale: {prescale_sel_hi, prescale_sel_lo}, mult_en: multiplier_enable,
		ref_lvl: ref_clk_in, align: align_reset};

	// Next-state logic for the whole block
	always_comb begin
		next_s = s;
		// Synchroniser chain; stage one feeds only stage two
		next_s.s1 = pins_raw;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// A level counts only once stages two and three agree
		agree = ~(s.s2 ^ s.s3);
		next_s.pins = (s.pins & ~agree) | (s.s3 & agree);
		next_s.ref_prev = s.pins.ref_lvl;
		next_s.align_prev = s.pins.align;
		ref_rise = s.pins.ref_lvl & ~s.ref_prev;
		align_rise = s.pins.align & ~s.align_prev;

		// Prescaler after the oscillator
		ratio = 4'h1 << s.pins.prescale;
		div_last = 3'(ratio - 4'h1);
		pll_tick = (s.div_cnt >= div_last);
		next_s.div_cnt = pll_tick ? dcm_pkg::DIV_RESET : 3'(s.div_cnt + 3'h1);

		// Disabled loop takes the DAC rate straight from the reference
		tick = s.pins.mult_en ? pll_tick : ref_rise;
		ph_last = s.pins.zero_stuff ? dcm_pkg::PH_LAST_ZS : dcm_pkg::PH_LAST_BB;
		wrap = (s.ph == ph_last);

		// Rate enables and phase; 4x only runs while stuffing
		next_s.clk_en = '0;
		next_s.latch_strobe = 1'b0;
		next_s.dac_update = 1'b0;
		if (tick) begin
			next_s.clk_en.en4x = s.pins.zero_stuff;
			// 2x pulses fall on odd phases when stuffing and on every tick otherwise, so the 1x pulse on the last phase nests in one
			next_s.clk_en.en2x = s.pins.zero_stuff ? s.ph[0] : 1'b1;
			next_s.clk_en.en1x = wrap;
			next_s.ph = wrap ? dcm_pkg::PH_RESET : 2'(s.ph + 2'h1);
			// 1x clock is high in the first half of the data period
			next_s.clk1x_lvl = s.pins.zero_stuff ? ~next_s.ph[1] : ~next_s.ph[0];
			// Capture coincides with the rising 1x edge
			if (wrap) begin
				next_s.latched_data = data_in;
				next_s.latch_strobe = 1'b1;
			end
			// Sample on even phases, midscale on odd ones when stuffing
			if (s.pins.zero_stuff && s.ph[0]) begin
				next_s.dac_code = dcm_pkg::MIDSCALE;
			end else begin
				next_s.dac_code = interp_data;
			end
			next_s.dac_update = 1'b1;
		end

		// Alignment: force the next tick to open a new data period
		if (!s.pins.mult_en && align_rise) begin
			next_s.ph = ph_last;
		end else if (s.pins.mult_en && ref_rise) begin
			next_s.ph = ph_last;
			next_s.div_cnt = div_last;
		end

		// Lock detection: count ticks per reference window
		expected = s.pins.zero_stuff ? dcm_pkg::TICKS_ZERO_STUF : dcm_pkg::TICKS_BASEBAND;
		if (!s.pins.mult_en) begin
			next_s.good = '0;
			next_s.locked = 1'b0;
			next_s.win_ticks = '0;
		end else if (ref_rise) begin
			if (s.win_ticks == expected) begin
				if (s.good != dcm_pkg::LOCK_WINDOWS) begin
					next_s.good = 3'(s.good + 3'h1);
				end
				next_s.locked = (s.good >= 3'(dcm_pkg::LOCK_WINDOWS - 3'h1));
			end else begin
				// One bad window drops lock at once
				next_s.good = '0;
				next_s.locked = 1'b0;
			end
			next_s.win_ticks = {3'h0, pll_tick};
		end else if (pll_tick && s.win_ticks != dcm_pkg::TICKS_MAX) begin
			next_s.win_ticks = 4'(s.win_ticks + 4'h1);
		end

		// Dither source; the pin looks random until lock
		next_s.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};

		// Shared pin: lock level, dither, or 1x clock when disabled
		if (!s.pins.mult_en) begin
			next_s.lock_out = s.clk1x_lvl;
		end else if (s.locked) begin
			next_s.lock_out = 1'b1;
		end else begin
			next_s.lock_out = s.lfsr[0];
		end
		next_s.highpass_out = s.pins.highpass;
	end

	// State register; reset values are constants only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.lfsr <= dcm_pkg::LFSR_SEED;
			s.div_cnt <= dcm_pkg::DIV_RESET;
			s.ph <= dcm_pkg::PH_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from state flip-flops
	assign lock_or_clk1x_out = s.lock_out;
	assign locked = s.locked;
	assign en1x = s.clk_en.en1x;
	assign en2x = s.clk_en.en2x;
	assign en4x = s.clk_en.en4x;
	assign latched_data = s.latched_data;
	assign latch_strobe = s.latch_strobe;
	assign dac_code = s.dac_code;
	assign dac_update = s.dac_update;
	assign highpass_out = s.highpass_out;

	default clocking dcm_cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Prescaler count stays inside the chosen ratio
	prescale_bound_a: assert property (s.div_cnt <= div_last || $changed(s.pins.prescale)
		|| $past(s.pins.mult_en && ref_rise)) else $error("prescaler count out of range");
	// Every 1x pulse coincides with a 2x pulse
	rate_nest_a: assert property (s.clk_en.en1x |-> s.clk_en.en2x)
		else $error("1x pulse without 2x pulse");
	// 4x pulses only while stuffing was selected
	four_x_mode_a: assert property (s.clk_en.en4x |-> $past(s.pins.zero_stuff))
		else $error("4x pulse outside zero-stuff mode");
	// Locked loop drives the pin high
	lock_high_a: assert property (s.locked && s.pins.mult_en |=> s.lock_out)
		else $error("lock pin low while locked");
	// Unlocked loop shows the dither bit
	unlock_dither_a: assert property (!s.locked && s.pins.mult_en |=> s.lock_out == $past(s.lfsr[0]))
		else $error("lock pin not dithering while unlocked");
	// Disabled loop shows the 1x clock on the pin
	clk1x_pin_a: assert property (!s.pins.mult_en |=> s.lock_out == $past(s.clk1x_lvl))
		else $error("1x clock missing on lock pin");
	// Capture happens with the 1x clock high
	capture_edge_a: assert property (s.latch_strobe |-> s.clk1x_lvl && s.clk_en.en1x)
		else $error("capture away from rising 1x edge");
	// Align reset forces the next period start
	align_phase_a: assert property (!s.pins.mult_en && align_rise |=> s.ph == $past(ph_last))
		else $error("align reset did not realign phase");
	// Reference edge realigns the prescaler when enabled
	ref_align_a: assert property (s.pins.mult_en && ref_rise |=> s.div_cnt == $past(div_last))
		else $error("reference edge did not realign prescaler");
	// Odd stuffing phase carries midscale
	midscale_a: assert property (s.dac_update && $past(s.pins.zero_stuff) && $past(s.ph[0])
		|-> s.dac_code == dcm_pkg::MIDSCALE) else $error("midscale sample missing");
	// Disabled loop updates only on reference edges
	ref_divide_a: assert property (!s.pins.mult_en && !ref_rise |=> !s.dac_update)
		else $error("update without reference edge");

	// Main scenarios
	lock_reached_c: cover property ($rose(s.locked));
	midscale_seen_c: cover property (s.dac_update && s.dac_code == dcm_pkg::MIDSCALE);
	disabled_capture_c: cover property (!s.pins.mult_en && s.latch_strobe);
	relock_c: cover property ($fell(s.locked) ##[1:200] $rose(s.locked));

endmodule // dcm_clock_dist

// File: dcm_far_side.sv
/* Far-side model: reference clock source and external data source.
   Assumes clk is the bench clock and the bench sets the reference half period. */
`timescale 1ns/1ps
module dcm_far_side (
	input  wire logic        clk,       // Bench clock
	input  wire logic        rst_n,     // Reset, active low
	input  wire logic        run,       // Reference runs while high
	input  wire logic [5:0]  half,      // Reference half period in clk cycles
	input  wire logic        pin_1x,    // Lock pin, read as the 1x clock
	input  wire logic        inv,       // Launch from the inverted 1x clock
	input  wire logic [13:0] next_word, // Word to launch next
	output logic             ref_clk,   // Reference clock pin
	output logic      [13:0] data       // Data bus to the device
);
	logic [5:0] cnt;   // Cycles spent in this half period
	logic       pin_q; // Lock pin one cycle ago
	// Reference stands low outside a run, so no stray edge reaches the loop
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 6'h00;
			ref_clk <= 1'b0;
		end else if (!run) begin
			cnt <= 6'h00;
			ref_clk <= 1'b0;
		end else if (cnt + 6'h01 >= half) begin
			cnt <= 6'h00;
			ref_clk <= !ref_clk;
		end else begin
			cnt <= cnt + 6'h01;
		end
	end
	// New word just after the 1x rise, so it is stable at the next rise
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
			data <= 14'h0000;
		end else begin
			pin_q <= pin_1x;
			// Inverted use launches on the falling pin edge instead
			if ((pin_1x ^ inv) && !(pin_q ^ inv)) data <= next_word;
		end
	end
endmodule // dcm_far_side

// File: dcm_pkg.sv
/*
 * Shared constants and types for the DAC clock multiplier and distribution block.
 * Assumes one system clock and that every user of these names writes dcm_pkg::name.
 */
package dcm_pkg;

	localparam int          DATA_W          = 14;        // DAC sample width
	localparam logic [13:0] MIDSCALE        = 14'h2000;  // Inserted sample in zero-stuff mode
	localparam logic [3:0]  TICKS_BASEBAND  = 4'h2;      // DAC ticks per reference, no stuffing
	localparam logic [3:0]  TICKS_ZERO_STUF = 4'h4;      // DAC ticks per reference, stuffing
	localparam logic [3:0]  TICKS_MAX       = 4'hF;      // Saturation of the window counter
	localparam logic [2:0]  LOCK_WINDOWS    = 3'h4;      // Good windows needed to declare lock
	localparam logic [7:0]  LFSR_SEED       = 8'hA5;     // Unlock dither start value
	localparam logic [1:0]  PH_LAST_ZS      = 2'h3;      // Last 4x phase in a data period
	localparam logic [1:0]  PH_LAST_BB      = 2'h1;      // Last 2x phase in a data period
	localparam logic [2:0]  DIV_RESET       = 3'h0;      // Prescaler count after reset
	localparam logic [1:0]  PH_RESET        = 2'h0;      // Phase count after reset

	// Pins that arrive from outside the clock domain
	typedef struct packed {
		logic       zero_stuff;  // Zero-stuffing select
		logic       highpass;    // Filter high-pass select
		logic [1:0] prescale;    // {prescale_sel_hi, prescale_sel_lo}
		logic       mult_en;     // Multiplier enabled
		logic       ref_lvl;     // Reference clock level
		logic       align;       // Divider alignment reset
	} dcm_pins_t;

	// Rate enables, one-cycle pulses
	typedef struct packed {
		logic en1x;
		logic en2x;
		logic en4x;
	} dcm_clk_en_t;

	// Whole state of the block
	typedef struct packed {
		dcm_pins_t   s1;           // Synchroniser stage 1
		dcm_pins_t   s2;           // Synchroniser stage 2
		dcm_pins_t   s3;           // Synchroniser stage 3
		dcm_pins_t   pins;         // Filtered pin levels
		logic        ref_prev;     // Reference level one cycle ago
		logic        align_prev;   // Align level one cycle ago
		logic [2:0]  div_cnt;      // Prescaler count
		logic [1:0]  ph;           // Phase within one data period
		logic [3:0]  win_ticks;    // Ticks seen in current reference window
		logic [2:0]  good;         // Consecutive good windows
		logic        locked;       // Loop lock state
		logic [7:0]  lfsr;         // Dither source while unlocked
		dcm_clk_en_t clk_en;       // Rate enables
		logic        clk1x_lvl;    // 1x clock level
		logic        lock_out;     // Lock indication or 1x clock pin
		logic [13:0] latched_data; // Captured input word
		logic        latch_strobe; // Capture pulse
		logic [13:0] dac_code;     // Code to the converter
		logic        dac_update;   // Converter update pulse
		logic        highpass_out; // Filter response select
	} dcm_state_t;

endpackage

// File: tb_top.sv
/* Self-checking bench for the clock block: reset, fixed-rate modes, lock.
   Assumes the far-side model supplies the reference and the data words. */
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst_n, mult, zs, hp, ps_hi, ps_lo, run, align, pq, inv;
	logic [5:0]  half;                // Reference half period
	logic [13:0] interp, word, data;  // Stimulus words
	logic        ref_clk, lpin, locked, en1x, en2x, en4x, lstb, dupd, hpo;
	logic [13:0] ldat, dcode;         // Captured word and converter code
	logic [31:0] lfsr = 32'hC151;     // Fixed seed keeps runs repeatable
	int          errors, comparisons, cyc;
	int          c1, c2, c4, cu, cm, cr, clo; // Tallies over one window
	dcm_clock_dist dcm_clock_dist_i (.clk(clk), .rst_n(rst_n), .multiplier_enable(mult),
		.ref_clk_in(ref_clk), .align_reset(align), .zero_stuff_select(zs),
		.filter_highpass_select(hp), .prescale_sel_hi(ps_hi), .prescale_sel_lo(ps_lo),
		.data_in(data), .interp_data(interp), .lock_or_clk1x_out(lpin), .locked(locked),
		.en1x(en1x), .en2x(en2x), .en4x(en4x), .latched_data(ldat), .latch_strobe(lstb),
		.dac_code(dcode), .dac_update(dupd), .highpass_out(hpo));
	dcm_far_side dcm_far_side_i (.clk(clk), .rst_n(rst_n), .run(run), .half(half),
		.pin_1x(lpin), .inv(inv), .next_word(word), .ref_clk(ref_clk), .data(data));
	initial begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	// Hang guard: far above the few thousand cycles the tests take
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	function automatic logic [13:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[13:0];
	endfunction
	// DAC ticks in one data period for the stuffing select
	function automatic int per(input int s);
		return (s != 0) ? 4 : 2;
	endfunction
	// Window edges may cut one pulse either way
	function automatic logic near(input int a, input int b);
		return (a - b <= 1) && (b - a <= 1);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Apply a mode from a fresh reset so no stale lock survives
	task automatic setm(input logic m, input logic s, input logic [1:0] c, input int h);
		@(negedge clk);
		rst_n = 1'b0;
		mult = m;
		zs = s;
		{ps_hi, ps_lo} = c;
		half = h[5:0];
		@(negedge clk);
		rst_n = 1'b1;
		repeat (40) @(negedge clk);
	endtask
	// Count pulses for n cycles while feeding random words
	task automatic tally(input int n);
		{c1, c2, c4, cu, cm, cr, clo} = '0;
		repeat (n) begin
			@(negedge clk);
			interp = rnd() | 14'h1000;
			word = rnd();
			c1 += en1x;
			c2 += en2x;
			c4 += en4x;
			cu += dupd;
			cm += (dupd && dcode === dcm_pkg::MIDSCALE);
			cr += (lpin && !pq);
			pq = lpin;
			clo += !lpin;
			if (lstb !== 1'b0) chk(ldat, data);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		{mult, zs, hp, ps_hi, ps_lo, run, align, pq, inv} = '0;
		half = 6'h02;
		interp = 14'h0000;
		word = 14'h0000;
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		chk(|{lpin, locked, en1x, en2x, en4x, lstb, dupd, hpo, ldat, dcode}, 0);
		rst_n = 1'b1;
		run = 1'b1;
		// Multiplier off: 100 reference rises, one tick each
		for (int s = 0; s < 2; s++) begin
			inv = s[0];
			setm(1'b0, s[0], 2'h0, 2);
			tally(400);
			chk(near(c4, (s != 0) ? 100 : 0), 1);
			chk(near(c2, 200 / per(s)), 1);
			chk(near(c1, 100 / per(s)), 1);
			chk(near(cu, 100), 1);
			chk(near(cm, (s != 0) ? 50 : 0), 1);
			chk(near(cr, c1), 1);
			// Align pulse mid-run: the first tick after it must open a data period
			repeat (3) @(negedge clk);
			align = 1'b1;
			repeat (5) @(negedge clk);
			do @(negedge clk); while (dupd !== 1'b1);
			chk(en1x, 1);
			align = 1'b0;
			$display("fixed rate test %0d done", s);
		end
		// Multiplier on: every divider code in both stuffing modes
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 4; c++) begin
				setm(1'b1, s[0], c[1:0], (per(s) << c) >> 1);
				for (int i = 0; i < 400 && locked !== 1'b1; i++) @(negedge clk);
				if (half < 6'h02) begin
					// A reference toggling every cycle cannot pass the pin filter,
					// so the fastest baseband code stays unlocked on this clock
					chk(locked, 0);
				end else begin
					chk(locked, 1);
					tally(40 * half);
					chk(clo, 0);
					chk(near(c1, 20), 1);
					chk(near(c4, (s != 0) ? 80 : 0), 1);
				end
				$display("lock test %0d %0d done", s, c);
			end
		end
		// Reference at the wrong rate never locks and the pin dithers
		setm(1'b1, 1'b0, 2'h0, 3);
		tally(200);
		chk(locked, 0);
		chk(cr > 0 && clo > 0, 1);
		for (int v = 0; v < 2; v++) begin
			hp = v[0];
			repeat (8) @(negedge clk);
			chk(hpo, v[0]);
		end
		$display("unlock and filter select test done");
		print_verdict();
	end
endmodule // tb_top
